// [hw/ubg_baud_addr.sv]
`timescale 1ns/10ps

// Overview of operation
// RULE1: Transmit ticks from first or second timer
// RULE2: Receive source selected independently, same encoding
// RULE3: Baud rollover reloads count from reload bytes
// RULE4: Bit rate is overflow rate over sixteen
// RULE5: Internal clock increments every second oscillator cycle
// RULE6: Rate equals osc over 32 times span
// RULE7: Baud mode only when a source bit set
// RULE8: Baud rollover never sets overflow flag
// RULE9: Trigger fall sets flag, no reload, baud mode
// RULE10: Software leaves count and reload alone running
// RULE11: Software sets run bit separately otherwise
// RULE12: Software writes 34H or 36H for both
// RULE13: Trigger fall also reloads or captures, non-baud
// RULE14: Without trigger enable only overflow reloads
// RULE15: Missing stop bit sets framing error flag
// RULE16: Control bit 7 is framing flag or mode
// RULE17: Framing flag cleared only by software write
// RULE18: Nine-bit modes need ninth bit and match
// RULE19: Mode 1 needs stop bit and match
// RULE20: Mode 0 ignores multiprocessor enable
// RULE21: Given address is address AND mask
// RULE22: Broadcast address is address OR mask
// RULE23: Address and mask reset to zero
// RULE24: Separate receive and transmit tick dividers
module ubg_baud_addr (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_t1_overflow,
	input wire logic i_aux_ext_clock_pin,
	input wire logic i_ext_trigger_input,
	input wire ubg_pkg::ubg_rx_frame_t i_rx_frame,
	output logic o_tx_sample_tick,
	output logic o_tx_bit_tick,
	output logic o_rx_sample_tick,
	output logic o_rx_bit_tick,
	output logic o_rx_accept,
	output logic [1:0] o_serial_mode,
	output logic o_aux_overflow_flag,
	output logic o_ext_trigger_flag
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	ubg_pkg::ubg_tctl_t tctl; // Timer control byte
	ubg_pkg::ubg_sctl_t sctl; // Serial control, bit 7 holds the mode bit
	logic frame_err; // Framing error flag
	logic [7:0] pctl; // Power control byte
	logic [7:0] slave_addr; // Own address
	logic [7:0] slave_mask; // Address mask
	logic [15:0] reload; // Reload value, high and low
	logic [15:0] count; // Count, high and low
	logic [3:0] div_cnt; // Oscillator divider
	logic [3:0] div_limit; // Divider length for the current mode
	logic div_tick; // One pulse per timer step
	logic clk_meta, clk_sync, clk_last; // External clock pin synchroniser
	logic trg_meta, trg_sync, trg_last; // Trigger pin synchroniser
	logic clk_fall; // Falling edge on the clock pin
	logic trg_fall; // Falling edge on the trigger pin
	logic baud_mode; // Timer serves the serial port
	logic inc; // Timer steps this cycle
	logic t2_ovf; // Timer rolls over this cycle
	logic baud_ovf; // Rollover that feeds the serial port
	logic ext_event; // Enabled trigger edge
	logic wr, rd_setup; // Bus strobes
	logic mapped; // Address hits a register
	logic [7:0] rd_byte; // Read mux
	logic framing_sel; // Bit 7 acts as framing flag
	logic [1:0] mode; // Serial mode
	logic given_ok, bcast_ok; // Address compare results
	logic [7:0] bcast; // Broadcast address
	logic accept; // Frame raises receive done
	logic [1:0] src_ovf; // Per direction source pulse, 0 transmit, 1 receive
	logic [1:0] src_sel; // Per direction source select
	logic [3:0] pre [2]; // Per direction oversample counter
	logic [1:0] sample_q, bit_q; // Per direction registered ticks

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Zero wait states; read data is captured in the setup cycle
	assign o_pready = 1'b1;
	assign wr = i_psel && i_penable && i_pwrite;
	assign rd_setup = i_psel && !i_penable && !i_pwrite;
	assign framing_sel = pctl[ubg_pkg::PCTL_FRAMING_SELECT_POS];

	// Address decode and read mux
	always_comb begin
		mapped = 1'b1;
		rd_byte = 8'h00;
		case (i_paddr)
			ubg_pkg::ADDR_AUX_TIMER_CONTROL: rd_byte = tctl;
			ubg_pkg::ADDR_RELOAD_VALUE_LOW: rd_byte = reload[7:0];
			ubg_pkg::ADDR_RELOAD_VALUE_HIGH: rd_byte = reload[15:8];
			ubg_pkg::ADDR_AUX_COUNT_LOW: rd_byte = count[7:0];
			ubg_pkg::ADDR_AUX_COUNT_HIGH: rd_byte = count[15:8];
			ubg_pkg::ADDR_SERIAL_CONTROL_REG: begin
				// Bit 7 shows the framing flag or the mode bit
				rd_byte = {(framing_sel ? frame_err : sctl.serial_mode_high_bit), sctl[6:0]}; // [RULE16]
			end
			ubg_pkg::ADDR_POWER_CONTROL_REG: rd_byte = pctl;
			ubg_pkg::ADDR_SLAVE_ADDRESS_REG: rd_byte = slave_addr;
			ubg_pkg::ADDR_SLAVE_ADDRESS_MASK: rd_byte = slave_mask;
			default: mapped = 1'b0;
		endcase
	end

	// Error answer for unmapped addresses in the access phase
	assign o_pslverr = i_psel && i_penable && !mapped;

	// Read data register, upper bits read as zero
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_prdata <= ubg_pkg::PRDATA_RST;
		end else if (rd_setup) begin
			o_prdata <= {24'h00_0000, rd_byte};
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Two flops, then a history flop for edge detection
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			clk_meta <= 1'b1;
			clk_sync <= 1'b1;
			clk_last <= 1'b1;
			trg_meta <= 1'b1;
			trg_sync <= 1'b1;
			trg_last <= 1'b1;
		end else begin
			clk_meta <= i_aux_ext_clock_pin;
			clk_sync <= clk_meta;
			clk_last <= clk_sync;
			trg_meta <= i_ext_trigger_input;
			trg_sync <= trg_meta;
			trg_last <= trg_sync;
		end
	end

	assign clk_fall = clk_last && !clk_sync;
	assign trg_fall = trg_last && !trg_sync;

	// ----------------------------------------------------------------
	// Timer stepping
	// ----------------------------------------------------------------
	// Baud mode whenever either direction takes the timer
	assign baud_mode = tctl.rx_rate_source_select || tctl.tx_rate_source_select; // [RULE7]
	// State time in baud mode, machine cycle otherwise
	assign div_limit = baud_mode ? ubg_pkg::STATE_TIME_DIV : ubg_pkg::MACHINE_CYCLE_DIV; // [RULE5]
	assign div_tick = (div_cnt >= div_limit - 4'h1);

	// Free running oscillator divider, wraps early if the mode shortens it
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_cnt <= 4'h0;
		end else if (div_tick) begin
			div_cnt <= 4'h0;
		end else begin
			div_cnt <= div_cnt + 4'h1;
		end
	end

	// Step from the divider or from pin edges, gated by the run bit
	assign inc = tctl.aux_run_bit && (tctl.count_or_time_select ? clk_fall : div_tick); // [RULE4]
	assign t2_ovf = inc && (count == ubg_pkg::COUNT_TOP);
	assign baud_ovf = t2_ovf && baud_mode;
	assign ext_event = tctl.ext_trigger_enable && trg_fall;

	// ----------------------------------------------------------------
	// Count and reload registers
	// ----------------------------------------------------------------
	// Count: rollover reload, trigger reload, step, then software bytes
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count <= ubg_pkg::COUNT_RST;
		end else begin
			if (t2_ovf) begin
				// Baud and reload modes reload, capture mode wraps
				if (baud_mode || !tctl.capture_select) begin
					count <= reload; // [RULE3] [RULE14]
				end else begin
					count <= ubg_pkg::COUNT_RST;
				end
			end else if (ext_event && !baud_mode && !tctl.capture_select) begin
				// Trigger reload only outside baud mode
				count <= reload; // [RULE13] [RULE9]
			end else if (inc) begin
				count <= count + 16'h0001;
			end
			// Software bytes; software keeps off them while running
			if (wr && i_paddr == ubg_pkg::ADDR_AUX_COUNT_LOW) begin
				count[7:0] <= i_pwdata[7:0]; // [RULE10]
			end
			if (wr && i_paddr == ubg_pkg::ADDR_AUX_COUNT_HIGH) begin
				count[15:8] <= i_pwdata[7:0];
			end
		end
	end

	// Reload: capture on trigger in capture mode, then software bytes
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			reload <= ubg_pkg::COUNT_RST;
		end else begin
			if (ext_event && !baud_mode && tctl.capture_select) begin
				reload <= count; // [RULE13]
			end
			if (wr && i_paddr == ubg_pkg::ADDR_RELOAD_VALUE_LOW) begin
				reload[7:0] <= i_pwdata[7:0];
			end
			if (wr && i_paddr == ubg_pkg::ADDR_RELOAD_VALUE_HIGH) begin
				reload[15:8] <= i_pwdata[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Timer control and flags
	// ----------------------------------------------------------------
	// Software write, then hardware sets win over a clear
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tctl <= ubg_pkg::AUX_TIMER_CONTROL_RST;
		end else begin
			if (wr && i_paddr == ubg_pkg::ADDR_AUX_TIMER_CONTROL) begin
				tctl <= ubg_pkg::ubg_tctl_t'(i_pwdata[7:0]); // [RULE12] [RULE11]
			end
			// Overflow flag only outside baud mode
			if (t2_ovf && !baud_mode) begin
				tctl.aux_overflow_flag <= 1'b1; // [RULE8]
			end
			// Trigger edge flags in every mode
			if (ext_event) begin
				tctl.ext_trigger_flag <= 1'b1; // [RULE9]
			end
		end
	end

	assign o_aux_overflow_flag = tctl.aux_overflow_flag;
	assign o_ext_trigger_flag = tctl.ext_trigger_flag;

	// ----------------------------------------------------------------
	// Baud tick generation
	// ----------------------------------------------------------------
	// Index 0 is transmit, index 1 is receive
	assign src_sel = {tctl.rx_rate_source_select, tctl.tx_rate_source_select}; // [RULE2]

	generate
		for (genvar d = 0; d < 2; d++) begin : g_dir
			// Source: second timer when selected, else the first
			assign src_ovf[d] = src_sel[d] ? baud_ovf : i_t1_overflow; // [RULE1] [RULE2]

			// Own oversample counter per direction
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					pre[d] <= 4'h0;
					sample_q[d] <= 1'b0;
					bit_q[d] <= 1'b0;
				end else begin
					sample_q[d] <= src_ovf[d];
					bit_q[d] <= src_ovf[d] && (pre[d] == ubg_pkg::OVERSAMPLE_LAST); // [RULE4] [RULE6]
					if (src_ovf[d]) begin
						pre[d] <= pre[d] + 4'h1; // [RULE24]
					end
				end
			end
		end
	endgenerate

	assign o_tx_sample_tick = sample_q[0];
	assign o_tx_bit_tick = bit_q[0];
	assign o_rx_sample_tick = sample_q[1];
	assign o_rx_bit_tick = bit_q[1];

	// ----------------------------------------------------------------
	// Address registers
	// ----------------------------------------------------------------
	// Both clear at reset so every address matches
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			slave_addr <= ubg_pkg::SLAVE_ADDRESS_RST; // [RULE23]
			slave_mask <= ubg_pkg::SLAVE_MASK_RST;
			pctl <= ubg_pkg::POWER_CONTROL_RST;
		end else if (wr) begin
			if (i_paddr == ubg_pkg::ADDR_SLAVE_ADDRESS_REG) begin
				slave_addr <= i_pwdata[7:0];
			end
			if (i_paddr == ubg_pkg::ADDR_SLAVE_ADDRESS_MASK) begin
				slave_mask <= i_pwdata[7:0];
			end
			if (i_paddr == ubg_pkg::ADDR_POWER_CONTROL_REG) begin
				pctl <= i_pwdata[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Address recognition
	// ----------------------------------------------------------------
	// Given: compare only where the mask is one
	assign given_ok = ((i_rx_frame.data ^ slave_addr) & slave_mask) == 8'h00; // [RULE21]
	// Broadcast: ones of address OR mask must be ones
	assign bcast = slave_addr | slave_mask;
	assign bcast_ok = (i_rx_frame.data & bcast) == bcast; // [RULE22]
	assign mode = {sctl.serial_mode_high_bit, sctl.serial_mode_low_bit};
	assign o_serial_mode = mode;

	// Decide whether a finished frame raises receive done
	always_comb begin
		accept = 1'b0;
		case (mode)
			2'b00: accept = 1'b1; // [RULE20]
			2'b01: accept = !sctl.multiproc_enable || (i_rx_frame.stop && (given_ok || bcast_ok)); // [RULE19]
			default: accept = !sctl.multiproc_enable || (i_rx_frame.ninth && (given_ok || bcast_ok)); // [RULE18]
		endcase
	end

	// ----------------------------------------------------------------
	// Serial control, framing flag, accept pulse
	// ----------------------------------------------------------------
	// Software write first, receiver sets override a clear
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sctl <= ubg_pkg::SERIAL_CONTROL_RST;
			frame_err <= 1'b0;
			o_rx_accept <= 1'b0;
		end else begin
			o_rx_accept <= i_rx_frame.valid && accept;
			if (wr && i_paddr == ubg_pkg::ADDR_SERIAL_CONTROL_REG) begin
				sctl[6:0] <= i_pwdata[6:0];
				// Bit 7 goes to the framing flag or the mode bit
				if (framing_sel) begin
					frame_err <= i_pwdata[7]; // [RULE16] [RULE17]
				end else begin
					sctl.serial_mode_high_bit <= i_pwdata[7];
				end
			end
			// Missing stop bit flags a framing error
			if (i_rx_frame.valid && !i_rx_frame.stop) begin
				frame_err <= 1'b1; // [RULE15]
			end
			// Accepted frame: receive done, and ninth bit in modes 2 and 3 or stop bit in modes 0 and 1
			if (i_rx_frame.valid && accept) begin
				sctl.receive_done_flag <= 1'b1;
				sctl.rx_ninth_bit <= mode[1] ? i_rx_frame.ninth : i_rx_frame.stop;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_tx_source_one: assert property ( // [RULE1]
		(!tctl.tx_rate_source_select && i_t1_overflow) |=> o_tx_sample_tick)
		else $error("transmit tick missing from first timer");

	a_rx_source_two: assert property ( // [RULE2]
		(tctl.rx_rate_source_select && !baud_ovf) |=> !o_rx_sample_tick)
		else $error("receive tick without second timer rollover");

	a_baud_reload: assert property ( // [RULE3]
		(baud_ovf && !wr) |=> (count == $past(reload)))
		else $error("baud rollover did not reload count");

	a_bit_per_sixteen: assert property ( // [RULE4]
		o_rx_bit_tick |-> (o_rx_sample_tick && pre[1] == 4'h0))
		else $error("receive bit tick not on sixteenth overflow");

	a_state_time_step: assert property ( // [RULE5]
		(baud_mode && div_tick && $stable(baud_mode)) |=> (!div_tick ##1 (div_tick || !baud_mode)))
		else $error("baud mode step is not every second cycle");

	a_baud_no_flag: assert property ( // [RULE8]
		(baud_ovf && !tctl.aux_overflow_flag && !wr) |=> !tctl.aux_overflow_flag)
		else $error("baud rollover set overflow flag");

	a_trig_no_reload: assert property ( // [RULE9]
		(baud_mode && ext_event && !inc && !wr) |=> (tctl.ext_trigger_flag && count == $past(count)))
		else $error("trigger in baud mode reloaded or missed flag");

	a_framing_set: assert property ( // [RULE15]
		(i_rx_frame.valid && !i_rx_frame.stop) |=> frame_err)
		else $error("missing stop bit not flagged");

	a_framing_sticky: assert property ( // [RULE17]
		(frame_err && !(wr && i_paddr == ubg_pkg::ADDR_SERIAL_CONTROL_REG)) |=> frame_err)
		else $error("framing flag cleared without a write");

	a_ninth_filter: assert property ( // [RULE18]
		(i_rx_frame.valid && mode[1] && sctl.multiproc_enable && !i_rx_frame.ninth) |=> !o_rx_accept)
		else $error("data frame accepted in address mode");

	a_mode0_ignore: assert property ( // [RULE20]
		(i_rx_frame.valid && mode == 2'b00) |=> (o_rx_accept && sctl.receive_done_flag))
		else $error("mode 0 frame not accepted");

endmodule : ubg_baud_addr

// [hw/ubg_pkg.sv]
package ubg_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets on the APB slave
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_AUX_TIMER_CONTROL = 8'h00; // Timer mode, sources, flags
	localparam logic [7:0] ADDR_RELOAD_VALUE_LOW = 8'h04; // Reload byte, low
	localparam logic [7:0] ADDR_RELOAD_VALUE_HIGH = 8'h08; // Reload byte, high
	localparam logic [7:0] ADDR_AUX_COUNT_LOW = 8'h0C; // Count byte, low
	localparam logic [7:0] ADDR_AUX_COUNT_HIGH = 8'h10; // Count byte, high
	localparam logic [7:0] ADDR_SERIAL_CONTROL_REG = 8'h14; // Serial mode and receive flags
	localparam logic [7:0] ADDR_POWER_CONTROL_REG = 8'h18; // Holds the framing select bit
	localparam logic [7:0] ADDR_SLAVE_ADDRESS_REG = 8'h1C; // Own slave address
	localparam logic [7:0] ADDR_SLAVE_ADDRESS_MASK = 8'h20; // Address mask

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int PCTL_FRAMING_SELECT_POS = 6; // Framing select bit in power control
	localparam logic [7:0] AUX_TIMER_CONTROL_RST = 8'h00; // All timer bits clear
	localparam logic [7:0] SERIAL_CONTROL_RST = 8'h00; // Mode 0, flags clear
	localparam logic [7:0] POWER_CONTROL_RST = 8'h00; // Framing select clear
	localparam logic [7:0] SLAVE_ADDRESS_RST = 8'h00; // Match every address
	localparam logic [7:0] SLAVE_MASK_RST = 8'h00; // All bits don't-care
	localparam logic [15:0] COUNT_RST = 16'h0000; // Count and reload after reset
	localparam logic [15:0] COUNT_TOP = 16'hFFFF; // Rollover point
	localparam logic [31:0] PRDATA_RST = 32'h0000_0000; // Read data after reset

	// ----------------------------------------------------------------
	// Cycle counts
	// ----------------------------------------------------------------
	localparam logic [3:0] STATE_TIME_DIV = 4'h2; // Oscillator cycles per state time
	localparam logic [3:0] MACHINE_CYCLE_DIV = 4'hC; // Oscillator cycles per machine cycle
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hF; // Sixteen overflows per serial bit

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	// Timer control byte, bit 7 first
	typedef struct packed {
		logic aux_overflow_flag;
		logic ext_trigger_flag;
		logic rx_rate_source_select;
		logic tx_rate_source_select;
		logic ext_trigger_enable;
		logic aux_run_bit;
		logic count_or_time_select;
		logic capture_select;
	} ubg_tctl_t;

	// Serial control byte, bit 7 first
	typedef struct packed {
		logic serial_mode_high_bit;
		logic serial_mode_low_bit;
		logic multiproc_enable;
		logic rx_enable;
		logic tx_ninth_bit;
		logic rx_ninth_bit;
		logic tx_done_flag;
		logic receive_done_flag;
	} ubg_sctl_t;

	// One frame as handed over by the base receiver
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic ninth;
		logic stop;
	} ubg_rx_frame_t;

endpackage : ubg_pkg

// [verification/ubg_frame_src.sv]
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Remote node: hands whole frames to the receive side
// ----------------------------------------------------------------
module ubg_frame_src (
	input wire logic i_clk,
	output ubg_pkg::ubg_rx_frame_t o_rx_frame
);
	// Idle: not valid
	initial o_rx_frame = '0;

	// One-cycle valid pulse, then the payload turns to its inverse so stale data is never mistaken
	task automatic send(input logic [7:0] data, input logic ninth, input logic stop);
		@(posedge i_clk);
		o_rx_frame <= '{valid: 1'b1, data: data, ninth: ninth, stop: stop};
		@(posedge i_clk);
		o_rx_frame <= '{valid: 1'b0, data: ~data, ninth: ~ninth, stop: ~stop};
	endtask : send
endmodule : ubg_frame_src

// [verification/testbench.sv]
`timescale 1ns/10ps

module testbench;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic i_clk;
	logic i_rst_n;
	logic i_psel;
	logic i_penable;
	logic i_pwrite;
	logic [7:0] i_paddr;
	logic [31:0] i_pwdata;
	logic [31:0] o_prdata;
	logic o_pready;
	logic o_pslverr;
	logic i_t1_overflow;
	logic i_ext_trigger_input;
	logic ext_clk; // External timer clock pin, one fall every 4 cycles
	ubg_pkg::ubg_rx_frame_t rx_frame;
	logic o_tx_bit_tick;
	logic o_rx_bit_tick;
	logic o_aux_overflow_flag;
	int fail_count = 0;
	int n_checks = 0;
	int seed = 559;
	int t1_cnt = 0;
	logic [32:0] exp_q[$]; // Expected {pslverr, prdata} per read
	// Frame table: serial control, data, {ninth, stop}, expected serial control after
	logic [7:0] t_sc[7] = '{8'hE0, 8'hE0, 8'hE0, 8'hE0, 8'h60, 8'h60, 8'h20};
	logic [7:0] t_d[7] = '{8'hC2, 8'hC1, 8'hC0, 8'hFF, 8'hC2, 8'hC2, 8'hC1};
	logic [1:0] t_ns[7] = '{2'b11, 2'b11, 2'b01, 2'b11, 2'b01, 2'b00, 2'b01};
	logic [7:0] t_e[7] = '{8'hE5, 8'hE0, 8'hE0, 8'hE5, 8'h65, 8'h60, 8'h25};

	// ----------------------------------------------------------------
	// Clock and first-timer overflow, one pulse every 8 cycles
	// ----------------------------------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		t1_cnt <= (t1_cnt + 1) % 8;
		i_t1_overflow <= (t1_cnt == 7);
		ext_clk <= t1_cnt[1];
	end

	// ----------------------------------------------------------------
	// Design and remote node
	// ----------------------------------------------------------------
	ubg_baud_addr ubg_baud_addr_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_t1_overflow(i_t1_overflow),
		.i_aux_ext_clock_pin(ext_clk), .i_ext_trigger_input(i_ext_trigger_input), .i_rx_frame(rx_frame),
		.o_tx_sample_tick(), .o_tx_bit_tick(o_tx_bit_tick), .o_rx_sample_tick(),
		.o_rx_bit_tick(o_rx_bit_tick), .o_rx_accept(), .o_serial_mode(),
		.o_aux_overflow_flag(o_aux_overflow_flag), .o_ext_trigger_flag());
	ubg_frame_src ubg_frame_src_inst (.i_clk(i_clk), .o_rx_frame(rx_frame));

	// ----------------------------------------------------------------
	// Compare, report, finish
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	// Monitor: each completed read takes the oldest note off the queue
	always @(posedge i_clk) begin : read_monitor
		logic [32:0] e;
		if (i_psel && i_penable && o_pready && !i_pwrite) begin
			e = exp_q.pop_front();
			check("prdata", e[31:0], o_prdata);
			check("pslverr", {31'h0, e[32]}, {31'h0, o_pslverr});
		end
	end

	// ----------------------------------------------------------------
	// APB master: setup, access held until pready, then release
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] data, input logic [32:0] exp);
		int k;
		logic [31:0] r;
		r = $random(seed);
		if (!wr) exp_q.push_back(exp);
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= addr;
		i_pwdata <= {r[31:8], data};
		@(posedge i_clk);
		i_penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge i_clk);
			if (o_pready === 1'b1) break;
		end
		if (k == 50) begin
			fail_count++;
			tally_and_finish();
		end
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		apb(1'b1, addr, data, 33'h0);
	endtask : wr

	task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
		apb(1'b0, addr, 8'h00, {25'h0, exp});
	endtask : rd

	// Cycles between two bit ticks of one direction, bounded
	task automatic period(input logic rx, input int exp);
		int k;
		int t0;
		t0 = -1;
		for (k = 0; k < 2000; k++) begin
			@(posedge i_clk);
			#1;
			if ((rx ? o_rx_bit_tick : o_tx_bit_tick) === 1'b1) begin
				if (t0 >= 0) break;
				t0 = k;
			end
		end
		if (k == 2000) begin
			fail_count++;
			tally_and_finish();
		end
		check(rx ? "rx bit period" : "tx bit period", 32'(exp), 32'(k - t0));
	endtask : period

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin : main
		int i;
		logic [31:0] r;
		i_rst_n = 1'b0;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 8'h00;
		i_pwdata = 32'h0000_0000;
		i_t1_overflow = 1'b0;
		i_ext_trigger_input = 1'b1;
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		// Reset values, then an unmapped place
		for (i = 0; i < 9; i++) rd(8'(i * 4), 8'h00);
		apb(1'b0, 8'h24, 8'h00, {1'b1, 32'h0000_0000});
		// Baud mode both ways, reload FFFE: 32 x 2 cycles per bit
		wr(ubg_pkg::ADDR_RELOAD_VALUE_LOW, 8'hFE);
		wr(ubg_pkg::ADDR_RELOAD_VALUE_HIGH, 8'hFF);
		// Count starts at the reload value, not at zero, so the first rollover comes soon
		wr(ubg_pkg::ADDR_AUX_COUNT_LOW, 8'hFE);
		wr(ubg_pkg::ADDR_AUX_COUNT_HIGH, 8'hFF);
		wr(ubg_pkg::ADDR_AUX_TIMER_CONTROL, 8'h34);
		period(1'b0, 64);
		period(1'b1, 64);
		rd(ubg_pkg::ADDR_AUX_TIMER_CONTROL, 8'h34);
		check("overflow flag", 32'h0, {31'h0, o_aux_overflow_flag});
		// Split sources: first timer is 8 cycles x 16
		wr(ubg_pkg::ADDR_AUX_TIMER_CONTROL, 8'h14);
		period(1'b1, 128);
		period(1'b0, 64);
		wr(ubg_pkg::ADDR_AUX_TIMER_CONTROL, 8'h24);
		period(1'b0, 128);
		// Trigger fall in baud mode sets the flag only
		wr(ubg_pkg::ADDR_AUX_TIMER_CONTROL, 8'h1C);
		i_ext_trigger_input <= 1'b0;
		repeat (8) @(posedge i_clk);
		rd(ubg_pkg::ADDR_AUX_TIMER_CONTROL, 8'h5C);
		period(1'b0, 64);
		i_ext_trigger_input <= 1'b1;
		// Auto-reload from FFFE: overflow flag after two 12-cycle steps
		wr(ubg_pkg::ADDR_AUX_TIMER_CONTROL, 8'h00);
		wr(ubg_pkg::ADDR_AUX_COUNT_LOW, 8'hFE);
		wr(ubg_pkg::ADDR_AUX_COUNT_HIGH, 8'hFF);
		wr(ubg_pkg::ADDR_AUX_TIMER_CONTROL, 8'h08);
		wr(ubg_pkg::ADDR_AUX_TIMER_CONTROL, 8'h0C);
		repeat (40) @(posedge i_clk);
		rd(ubg_pkg::ADDR_AUX_TIMER_CONTROL, 8'h8C);
		i_ext_trigger_input <= 1'b0;
		repeat (8) @(posedge i_clk);
		rd(ubg_pkg::ADDR_AUX_TIMER_CONTROL, 8'hCC);
		// Baud mode counting pin falls: two 4-cycle steps per rollover, x 16
		wr(ubg_pkg::ADDR_AUX_TIMER_CONTROL, 8'h16);
		period(1'b0, 128);
		// Address recognition: given 1100 00X0, broadcast 1111 11X1
		wr(ubg_pkg::ADDR_SLAVE_ADDRESS_REG, 8'hC0);
		wr(ubg_pkg::ADDR_SLAVE_ADDRESS_MASK, 8'hFD);
		for (i = 0; i < 7; i++) begin
			wr(ubg_pkg::ADDR_SERIAL_CONTROL_REG, t_sc[i]);
			ubg_frame_src_inst.send(t_d[i], t_ns[i][1], t_ns[i][0]);
			repeat (2) @(posedge i_clk);
			rd(ubg_pkg::ADDR_SERIAL_CONTROL_REG, t_e[i]);
		end
		// Power control storage with random contents, framing select kept clear
		r = $random(seed);
		wr(ubg_pkg::ADDR_POWER_CONTROL_REG, r[7:0] & 8'hBF);
		rd(ubg_pkg::ADDR_POWER_CONTROL_REG, r[7:0] & 8'hBF);
		// Framing flag in bit 7: set by a missing stop, cleared only by a write
		wr(ubg_pkg::ADDR_POWER_CONTROL_REG, 8'h40);
		wr(ubg_pkg::ADDR_SERIAL_CONTROL_REG, 8'h60);
		ubg_frame_src_inst.send(8'hC2, 1'b0, 1'b0);
		repeat (2) @(posedge i_clk);
		rd(ubg_pkg::ADDR_SERIAL_CONTROL_REG, 8'hE0);
		ubg_frame_src_inst.send(8'hC2, 1'b0, 1'b1);
		repeat (2) @(posedge i_clk);
		rd(ubg_pkg::ADDR_SERIAL_CONTROL_REG, 8'hE5);
		wr(ubg_pkg::ADDR_POWER_CONTROL_REG, 8'h00);
		rd(ubg_pkg::ADDR_SERIAL_CONTROL_REG, 8'h65);
		wr(ubg_pkg::ADDR_POWER_CONTROL_REG, 8'h40);
		wr(ubg_pkg::ADDR_SERIAL_CONTROL_REG, 8'h60);
		rd(ubg_pkg::ADDR_SERIAL_CONTROL_REG, 8'h60);
		repeat (2) @(posedge i_clk);
		tally_and_finish();
	end
endmodule : testbench
